//--- pkg/dsa_pkg.sv
// Package for the debug serial auto-baud front end.
// Assumes a single 25 MHz system clock for all users.
package dsa_pkg;
    // Character framing.
    localparam int unsigned DATA_BITS      = 8;
    localparam int unsigned FRAME_BITS     = 10;
    // Fixed first character and its low run in bit times.
    localparam logic [7:0]  AUTOBAUD_CHAR  = 8'h80;
    localparam int unsigned AUTOBAUD_BITS  = 8;
    // Slowest link: system clock divided by this.
    localparam int unsigned MIN_RATE_DIV   = 512;
    localparam int unsigned PERIOD_W       = 10;
    localparam int unsigned MEAS_W         = PERIOD_W + 3;
    // Reset values.
    localparam logic        DBG_ACTIVE_RST = 1'b0;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 10'h000;

    typedef enum logic [4:0] {
        ST_WAIT_HIGH = 5'b00001,
        ST_MEASURE   = 5'b00010,
        ST_RX        = 5'b00100,
        ST_TX        = 5'b01000,
        ST_IDLE      = 5'b10000
    } dsa_state_t;
endpackage

//--- hw/dsa_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module dsa_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    logic [WIDTH-1:0] mem_r [2];
    logic [WIDTH-1:0] mem_nxt [2];
    logic             wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0]       cnt_r, cnt_nxt;
    logic             push, pop;

    assign in_ready_out  = (cnt_r != 2'h2);
    assign out_valid_out = (cnt_r != 2'h0);
    assign out_data_out  = mem_r[rp_r];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data_in;
            wp_nxt = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            wp_r     <= 1'b0;
            rp_r     <= 1'b0;
            cnt_r    <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    buf_never_over_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cnt_r <= 2'h2) else $error("buffer count above two");
endmodule

//--- hw/dsa_top.sv
// Debug serial front end: auto-baud, receive, reply and debug state exit.
// Assumes a 25 MHz system clock and an open-drain shared pin pulled up outside.
// Summary of operation
// RULE1 - Debug state ends when the debug-mode-active bit is written to zero.
// RULE2 - Debug state ends on power-on, brownout, watchdog or reset pin reset.
// RULE3 - Pin driven low during low-power halt starts a system reset.
// RULE4 - Characters are one start, eight data LSB first, one stop.
// RULE5 - Reply may start right after the request frame's stop bit.
// RULE6 - Host drives stop bit high for at most half a bit time.
// RULE7 - Host should drive the shared pin open drain.
// RULE8 - After reset stay idle, transmit nothing until a character arrives.
// RULE9 - Host's first character is 80H, eight bit times low.
// RULE10 - Time the first low period and load the bit period from it.
// RULE11 - Detector and bit-rate generator run on the system clock.
// RULE12 - Slowest supported rate is system clock divided by 512.
// RULE13 - Measured period times mid-bit sampling and outgoing bits.
`timescale 1ns/10ps
module dsa_top (
    // Clock and reset
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_N_IN,
    // Reset sources that end the debug state
    input  wire logic       POR_RST_IN,
    input  wire logic       BROWNOUT_RST_IN,
    input  wire logic       WATCHDOG_RST_IN,
    input  wire logic       RESET_PIN_N_IN,
    input  wire logic       HALT_MODE_IN,
    // Debug mode control
    input  wire logic       DEBUG_MODE_SET_IN,
    input  wire logic       DEBUG_MODE_CLR_IN,
    output logic            DEBUG_MODE_ACTIVE_OUT,
    output logic            SYS_RESET_REQ_OUT,
    // Shared debug serial pin
    input  wire logic       DEBUG_SERIAL_PIN_IN,
    output logic            DEBUG_SERIAL_PIN_OUT,
    output logic            DEBUG_SERIAL_PIN_OE_N_OUT,
    // Received characters
    output logic            RX_VALID_OUT,
    input  wire logic       RX_READY_IN,
    output logic [7:0]      RX_DATA_OUT,
    // Reply characters
    input  wire logic       TX_VALID_IN,
    output logic            TX_READY_OUT,
    input  wire logic [7:0] TX_DATA_IN,
    // Status
    output logic            BAUD_LOCKED_OUT,
    output logic [9:0]      BIT_PERIOD_OUT
);
    localparam int unsigned PW = dsa_pkg::PERIOD_W;
    localparam int unsigned MW = dsa_pkg::MEAS_W;

    // Pin synchroniser; stage one is read only by stage two.
    logic pin_s1_r, pin_s2_r, pin_prev_r;
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pin_s1_r   <= 1'b1;
            pin_s2_r   <= 1'b1;
            pin_prev_r <= 1'b1;
        end else begin
            pin_s1_r   <= DEBUG_SERIAL_PIN_IN;
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end
    logic fall;
    assign fall = pin_prev_r && !pin_s2_r;

    // Any documented reset source, synchronised where it comes from outside.
    logic [4:0] rsrc_s1_r, rsrc_s2_r;
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rsrc_s1_r <= 5'h00;
            rsrc_s2_r <= 5'h00;
        end else begin
            rsrc_s1_r <= {HALT_MODE_IN, !RESET_PIN_N_IN, WATCHDOG_RST_IN,
                          BROWNOUT_RST_IN, POR_RST_IN};
            rsrc_s2_r <= rsrc_s1_r;
        end
    end
    logic any_rst, halt_wake;
    // RULE3 halt pin reset
    assign halt_wake = rsrc_s2_r[4] && !pin_s2_r;
    // RULE2 reset sources
    assign any_rst = |rsrc_s2_r[3:0] || halt_wake;
    assign SYS_RESET_REQ_OUT = halt_wake;

    // Debug mode bit; clear and reset win over set.
    logic dbg_r, dbg_nxt;
    always_comb begin
        dbg_nxt = dbg_r;
        if (DEBUG_MODE_SET_IN) begin
            dbg_nxt = 1'b1;
        end
        // RULE1 software clear
        if (DEBUG_MODE_CLR_IN || any_rst) begin
            dbg_nxt = 1'b0;
        end
    end
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dbg_r <= dsa_pkg::DBG_ACTIVE_RST;
        end else begin
            dbg_r <= dbg_nxt;
        end
    end
    assign DEBUG_MODE_ACTIVE_OUT = dbg_r;

    // Serial engine.
    dsa_pkg::dsa_state_t st_r, st_nxt;
    logic [MW-1:0] cnt_r, cnt_nxt;
    logic [PW-1:0] per_r, per_nxt;
    logic          lock_r, lock_nxt;
    logic [3:0]    bit_r, bit_nxt;
    logic [9:0]    sh_r, sh_nxt;
    logic          drv_low_r, drv_low_nxt;
    logic          push;
    logic [7:0]    push_data;
    logic          buf_ready;
    logic [MW-1:0] half;

    assign half = {4'h0, per_r[PW-1:1]};

    always_comb begin
        st_nxt      = st_r;
        cnt_nxt     = cnt_r;
        per_nxt     = per_r;
        lock_nxt    = lock_r;
        bit_nxt     = bit_r;
        sh_nxt      = sh_r;
        drv_low_nxt = 1'b0;
        push        = 1'b0;
        push_data   = sh_r[8:1];
        case (st_r)
            // RULE8 idle until first character
            dsa_pkg::ST_WAIT_HIGH: begin
                if (fall) begin
                    // The cycle that shows the fall is already the first low clock.
                    st_nxt  = dsa_pkg::ST_MEASURE;
                    cnt_nxt = {{(MW-1){1'b0}}, 1'b1};
                end
            end
            // RULE10 time the low run
            dsa_pkg::ST_MEASURE: begin
                // RULE11 counts system clocks
                cnt_nxt = cnt_r + 1'b1;
                if (pin_s2_r) begin
                    // RULE12 period up to 1023 clocks
                    per_nxt  = cnt_r[MW-1:3];
                    lock_nxt = (cnt_r[MW-1:3] != '0);
                    st_nxt   = lock_nxt ? dsa_pkg::ST_IDLE : dsa_pkg::ST_WAIT_HIGH;
                    cnt_nxt  = '0;
                end else if (&cnt_r) begin
                    st_nxt = dsa_pkg::ST_WAIT_HIGH;
                end
            end
            dsa_pkg::ST_IDLE: begin
                if (fall) begin
                    st_nxt  = dsa_pkg::ST_RX;
                    cnt_nxt = half;
                    bit_nxt = '0;
                end else if (TX_VALID_IN) begin
                    // RULE5 reply right after stop
                    st_nxt  = dsa_pkg::ST_TX;
                    // RULE4 transmit framing
                    sh_nxt  = {1'b1, TX_DATA_IN, 1'b0};
                    bit_nxt = '0;
                    cnt_nxt = '0;
                end
            end
            dsa_pkg::ST_RX: begin
                // RULE13 mid-bit sampling
                if (cnt_r == '0) begin
                    cnt_nxt = {3'h0, per_r} - 1'b1;
                    sh_nxt  = {pin_s2_r, sh_r[9:1]};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'(dsa_pkg::FRAME_BITS - 1)) begin
                        // RULE4 start low, stop high
                        push   = pin_s2_r && !sh_r[1];
                        push_data = sh_r[9:2];
                        st_nxt = dsa_pkg::ST_IDLE;
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            dsa_pkg::ST_TX: begin
                drv_low_nxt = !sh_r[0];
                // RULE13 transmit bit timing
                if (cnt_r == {3'h0, per_r} - 1'b1) begin
                    cnt_nxt = '0;
                    sh_nxt  = {1'b1, sh_r[9:1]};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'(dsa_pkg::FRAME_BITS - 1)) begin
                        st_nxt = dsa_pkg::ST_IDLE;
                        drv_low_nxt = 1'b0;
                    end
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: st_nxt = dsa_pkg::ST_WAIT_HIGH;
        endcase
        // RULE2 reset source returns to auto-baud
        if (any_rst) begin
            st_nxt      = dsa_pkg::ST_WAIT_HIGH;
            lock_nxt    = 1'b0;
            drv_low_nxt = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_r      <= dsa_pkg::ST_WAIT_HIGH;
            cnt_r     <= '0;
            per_r     <= dsa_pkg::PERIOD_RST;
            lock_r    <= 1'b0;
            bit_r     <= 4'h0;
            sh_r      <= 10'h3ff;
            drv_low_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            per_r     <= per_nxt;
            lock_r    <= lock_nxt;
            bit_r     <= bit_nxt;
            sh_r      <= sh_nxt;
            drv_low_r <= drv_low_nxt;
        end
    end

    // Open drain: enable low only while pulling the pin low.
    assign DEBUG_SERIAL_PIN_OUT      = 1'b0;
    assign DEBUG_SERIAL_PIN_OE_N_OUT = !drv_low_r;
    assign TX_READY_OUT    = (st_r == dsa_pkg::ST_IDLE) && !fall && !any_rst;
    assign BAUD_LOCKED_OUT = lock_r;
    assign BIT_PERIOD_OUT  = per_r;

    // Up to two received words wait here while the consumer stalls; a third is lost.
    dsa_buf2 #(
        .WIDTH (dsa_pkg::DATA_BITS)
    ) u_rx_buf (
        .clk_in        (SYS_CLK_IN),
        .rst_n_in      (RST_N_IN),
        .in_valid_in   (push),
        .in_ready_out  (buf_ready),
        .in_data_in    (push_data),
        .out_valid_out (RX_VALID_OUT),
        .out_ready_in  (RX_READY_IN),
        .out_data_out  (RX_DATA_OUT)
    );

    // Assertions.
    clear_ends_dbg_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE1
        DEBUG_MODE_CLR_IN |=> !dbg_r) else $error("debug mode not cleared");
    reset_ends_dbg_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE2
        any_rst |=> !dbg_r && st_r == dsa_pkg::ST_WAIT_HIGH) else $error("reset kept debug");
    halt_pin_rst_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE3
        rsrc_s2_r[4] && !pin_s2_r |-> SYS_RESET_REQ_OUT ##1 !dbg_r && !lock_r)
        else $error("halt wake missed");
    start_bit_low_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE4
        $rose(st_r == dsa_pkg::ST_TX) |=> !DEBUG_SERIAL_PIN_OE_N_OUT)
        else $error("start bit not driven low");
    no_tx_unlocked_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE8
        !lock_r |-> DEBUG_SERIAL_PIN_OE_N_OUT) else $error("drove pin before lock");
    period_load_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE10
        st_r == dsa_pkg::ST_MEASURE && pin_s2_r |=> per_r == $past(cnt_r[MW-1:3]))
        else $error("bit period not loaded");
    period_limit_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE12
        lock_r |-> per_r != '0) else $error("locked with zero period");
    reply_idle_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE5
        st_r == dsa_pkg::ST_IDLE && TX_VALID_IN && !fall && !any_rst
        |=> st_r == dsa_pkg::ST_TX) else $error("reply not started");
    rx_push_ok_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) // RULE13
        push |-> buf_ready) else $error("received word lost");

    lock_c  : cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) $rose(lock_r));
    rx_c    : cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) push);
    tx_c    : cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $fell(st_r == dsa_pkg::ST_TX));
    halt_c  : cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) halt_wake);
endmodule

//--- tb/dsa_host_model.sv
// Debug host model on the shared serial pin.
// Assumes the pin is pulled up outside and driven by the bench at falling clock edges.
`timescale 1ns/10ps
module dsa_host_model (
    // Clock and pin level
    input  wire logic clk_in,
    input  wire logic pin_in,
    // Open-drain pull-down
    output logic      host_low_out
);
    int unsigned bit_clks;

    initial begin
        host_low_out = 1'b0;
        bit_clks     = 16;
    end

    task automatic set_rate(input int unsigned p);
        bit_clks = (p > dsa_pkg::MIN_RATE_DIV) ? dsa_pkg::MIN_RATE_DIV : p;
    endtask

    task automatic hold_low(input logic v);
        host_low_out = v;
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_low_out = ~frame[i];
            repeat (bit_clks) @(negedge clk_in);
        end
    endtask

    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int n;
        n  = 0;
        ok = 1'b0;
        b  = 8'h00;
        while (pin_in !== 1'b0 && n < 30 * bit_clks) begin
            @(negedge clk_in);
            n++;
        end
        if (pin_in === 1'b0) begin
            repeat (bit_clks / 2) @(negedge clk_in);
            ok = (pin_in === 1'b0);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks) @(negedge clk_in);
                b[i] = pin_in;
            end
            repeat (bit_clks) @(negedge clk_in);
            ok = ok && (pin_in === 1'b1);
        end
    endtask
endmodule

//--- tb/dsa_top_bench.sv
// Self-checking bench for the debug serial front end.
// Assumes a 25 MHz clock and an open-drain pin with an outside pull-up.
`timescale 1ns/10ps
module dsa_top_bench;
    logic       SYS_CLK_IN, RST_N_IN, POR_RST_IN, BROWNOUT_RST_IN, WATCHDOG_RST_IN;
    logic       RESET_PIN_N_IN, HALT_MODE_IN, DEBUG_MODE_SET_IN, DEBUG_MODE_CLR_IN;
    logic       DEBUG_MODE_ACTIVE_OUT, SYS_RESET_REQ_OUT, DEBUG_SERIAL_PIN_OUT;
    logic       DEBUG_SERIAL_PIN_OE_N_OUT, RX_VALID_OUT, RX_READY_IN, TX_VALID_IN;
    logic       TX_READY_OUT, BAUD_LOCKED_OUT, host_low;
    logic [7:0] RX_DATA_OUT, TX_DATA_IN;
    logic [9:0] BIT_PERIOD_OUT;
    wire        pin_w = host_low ? 1'b0 :
                        (DEBUG_SERIAL_PIN_OE_N_OUT ? 1'b1 : DEBUG_SERIAL_PIN_OUT);
    int         error_cnt = 0;
    int         num_checks = 0;

    dsa_top u_dsa_top (.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN),
        .POR_RST_IN(POR_RST_IN), .BROWNOUT_RST_IN(BROWNOUT_RST_IN),
        .WATCHDOG_RST_IN(WATCHDOG_RST_IN), .RESET_PIN_N_IN(RESET_PIN_N_IN),
        .HALT_MODE_IN(HALT_MODE_IN), .DEBUG_MODE_SET_IN(DEBUG_MODE_SET_IN),
        .DEBUG_MODE_CLR_IN(DEBUG_MODE_CLR_IN), .DEBUG_MODE_ACTIVE_OUT(DEBUG_MODE_ACTIVE_OUT),
        .SYS_RESET_REQ_OUT(SYS_RESET_REQ_OUT), .DEBUG_SERIAL_PIN_IN(pin_w),
        .DEBUG_SERIAL_PIN_OUT(DEBUG_SERIAL_PIN_OUT),
        .DEBUG_SERIAL_PIN_OE_N_OUT(DEBUG_SERIAL_PIN_OE_N_OUT), .RX_VALID_OUT(RX_VALID_OUT),
        .RX_READY_IN(RX_READY_IN), .RX_DATA_OUT(RX_DATA_OUT), .TX_VALID_IN(TX_VALID_IN),
        .TX_READY_OUT(TX_READY_OUT), .TX_DATA_IN(TX_DATA_IN),
        .BAUD_LOCKED_OUT(BAUD_LOCKED_OUT), .BIT_PERIOD_OUT(BIT_PERIOD_OUT));

    dsa_host_model u_dsa_host_model (.clk_in(SYS_CLK_IN), .pin_in(pin_w),
        .host_low_out(host_low));

    initial begin
        SYS_CLK_IN = 1'b0;
        forever #20 SYS_CLK_IN = ~SYS_CLK_IN;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge SYS_CLK_IN);
    endtask

    // Measures the 80H low run at period p and checks the lock.
    task automatic autobaud(input int unsigned p);
        int n;
        n = 0;
        RST_N_IN = 1'b0;
        tick(5);
        RST_N_IN = 1'b1;
        u_dsa_host_model.set_rate(p);
        for (int i = 0; i < 4 * p; i++) begin
            tick(1);
            if (DEBUG_SERIAL_PIN_OE_N_OUT !== 1'b1) n++;
        end
        chk(16'(n), 16'h0000);
        chk(16'(TX_READY_OUT), 16'h0000);
        u_dsa_host_model.send_byte(dsa_pkg::AUTOBAUD_CHAR);
        tick(4);
        chk(16'(BAUD_LOCKED_OUT), 16'h0001);
        chk(16'(BIT_PERIOD_OUT), 16'(p));
        chk(16'(RX_VALID_OUT), 16'h0000);
    endtask

    task automatic pop_rx(input logic [7:0] exp);
        int n;
        n = 0;
        while (RX_VALID_OUT !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk(16'(RX_DATA_OUT), 16'(exp));
        RX_READY_IN = 1'b1;
        tick(1);
        RX_READY_IN = 1'b0;
        tick(1);
    endtask

    // Two frames land while the receiver stalls, then a reply goes out.
    task automatic rx_tx(input logic [7:0] a, input logic [7:0] b, input logic [7:0] r);
        logic [7:0] got;
        bit         ok;
        int         n;
        u_dsa_host_model.send_byte(a);
        u_dsa_host_model.send_byte(b);
        tick(4);
        pop_rx(a);
        pop_rx(b);
        tick(2);
        chk(16'(RX_VALID_OUT), 16'h0000);
        fork
            u_dsa_host_model.recv_byte(got, ok);
            begin
                n = 0;
                TX_VALID_IN = 1'b1;
                TX_DATA_IN  = r;
                while (TX_READY_OUT !== 1'b1 && n < 100) begin
                    tick(1);
                    n++;
                end
                tick(1);
                TX_VALID_IN = 1'b0;
            end
        join
        chk(16'(ok), 16'h0001);
        chk(16'(got), 16'(r));
    endtask

    // Each exit cause drops the debug state; index 4 is the clear pulse.
    task automatic debug_exit();
        for (int i = 0; i < 5; i++) begin
            DEBUG_MODE_SET_IN = 1'b1;
            tick(1);
            DEBUG_MODE_SET_IN = 1'b0;
            tick(1);
            chk(16'(DEBUG_MODE_ACTIVE_OUT), 16'h0001);
            POR_RST_IN        = (i == 0);
            BROWNOUT_RST_IN   = (i == 1);
            WATCHDOG_RST_IN   = (i == 2);
            RESET_PIN_N_IN    = (i != 3);
            DEBUG_MODE_CLR_IN = (i == 4);
            tick(1);
            DEBUG_MODE_CLR_IN = 1'b0;
            tick(3);
            {POR_RST_IN, BROWNOUT_RST_IN, WATCHDOG_RST_IN, RESET_PIN_N_IN} = 4'h1;
            tick(4);
            chk(16'(DEBUG_MODE_ACTIVE_OUT), 16'h0000);
            if (i == 0) chk(16'(BAUD_LOCKED_OUT), 16'h0000);
        end
        {DEBUG_MODE_SET_IN, DEBUG_MODE_CLR_IN} = 2'h3;
        tick(1);
        {DEBUG_MODE_SET_IN, DEBUG_MODE_CLR_IN} = 2'h0;
        tick(1);
        chk(16'(DEBUG_MODE_ACTIVE_OUT), 16'h0000);
    endtask

    task automatic halt_wake();
        u_dsa_host_model.hold_low(1'b1);
        tick(5);
        chk(16'(SYS_RESET_REQ_OUT), 16'h0000);
        HALT_MODE_IN = 1'b1;
        tick(5);
        chk(16'(SYS_RESET_REQ_OUT), 16'h0001);
        u_dsa_host_model.hold_low(1'b0);
        tick(5);
        chk(16'(SYS_RESET_REQ_OUT), 16'h0000);
        HALT_MODE_IN = 1'b0;
    endtask

    initial begin
        {RST_N_IN, POR_RST_IN, BROWNOUT_RST_IN, WATCHDOG_RST_IN} = 4'h0;
        {HALT_MODE_IN, DEBUG_MODE_SET_IN, DEBUG_MODE_CLR_IN} = 3'h0;
        {RX_READY_IN, TX_VALID_IN} = 2'h0;
        RESET_PIN_N_IN = 1'b1;
        TX_DATA_IN     = 8'h00;
        autobaud(16);
        rx_tx(8'h5a, 8'h01, 8'ha5);
        autobaud(37);
        rx_tx(8'hff, 8'h80, 8'h3c);
        autobaud(512);
        rx_tx(8'h96, 8'h00, 8'h81);
        debug_exit();
        halt_wake();
        stop_test();
    end

    initial begin
        repeat (80000) @(posedge SYS_CLK_IN);
        error_cnt++;
        stop_test();
    end
endmodule
